// ===== verilog/ep_status_ctrl_defines.vh
`ifndef EP_STATUS_CTRL_DEFINES_VH
`define EP_STATUS_CTRL_DEFINES_VH

// ----------------------------------------------------------------------
// Register indices as printed (not word aligned, so index times four)
// ----------------------------------------------------------------------
`define IDX_NAK_WRITE_MASK      32'h0FFFFE03
`define IDX_SIE_STALL_RESUME    32'hFFFFFE04
`define IDX_CLEAR_REQ_RECORD    32'hFFFFFE05
`define IDX_SET_REQ_RECORD      32'hFFFFFE06
`define IDX_EP_STATUS_OCC       32'h0FFFFE07
`define IDX_BUS_SUSPEND_STATUS  32'hFFFFFE08
`define IDX_FIFO_CLEAR_A        32'hFFFFFE0A

// Byte address is four times the index; the two top bits fall off the
// 32-bit bus, which the address map already allows for
`define BYTE_ADDR(idx) ((idx) << 2)

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define NAK_MASK_B_BIT          3
`define NAK_MASK_A_BIT          2
`define FORCE_STALL_BIT         3
`define RESUME_DRIVE_BIT        0
`define SET_CONFIG_BIT          7
`define SET_FEAT_EP_BIT         2
`define SET_FEAT_DEV_BIT        0
`define SUSPEND_FLAG_BIT        7

// ----------------------------------------------------------------------
// Reset values and misc constants
// ----------------------------------------------------------------------
`define REG8_RESET              8'h00
`define RDATA_ZERO              32'h0000_0000
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2
`define FIFO_CLR_DELAY_USB      5

`endif

// ===== verilog/usb_function_ep_status_ctrl.v
`timescale 1ns/1ps
`include "ep_status_ctrl_defines.vh"

module usb_function_ep_status_ctrl #(
  parameter integer FIFO_CLR_DELAY = `FIFO_CLR_DELAY_USB
) (
  input  wire        clk_sys_i,
  input  wire        rstn_i,
  input  wire [31:0] s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output wire        s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output wire        s_axi_wready_o,
  output wire [1:0]  s_axi_bresp_o,
  output wire        s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [31:0] s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output wire        s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0]  s_axi_rresp_o,
  output wire        s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  input  wire        nak_ctrl_wr_i,
  input  wire [1:0]  nak_ctrl_wdata_i,
  output wire        bulk_out_b_nak_we_o,
  output wire        bulk_out_a_nak_we_o,
  output wire [1:0]  bulk_out_nak_wdata_o,
  input  wire        setup_token_i,
  input  wire        unsupported_wvalue_i,
  input  wire        auto_req_overrun_i,
  input  wire        fw_request_active_i,
  input  wire        remote_wakeup_enable_i,
  output wire        force_stall_o,
  output wire        resume_drive_o,
  input  wire [7:0]  clear_req_done_i,
  input  wire [2:0]  set_req_done_i,
  input  wire [1:0]  int_fifo_set_i,
  input  wire [1:0]  int_tx_done_i,
  input  wire [1:0]  bulk_out_toggle_i,
  input  wire [1:0]  bulk_out_cpu_empty_i,
  input  wire [1:0]  bulk_in_set_i,
  input  wire [1:0]  bulk_in_toggle_i,
  input  wire        ep0_tx_set_i,
  input  wire        ep0_tx_done_i,
  input  wire        ep0_rx_data_i,
  input  wire        ep0_rx_empty_i,
  input  wire        bus_suspend_evt_i,
  output wire [7:0]  fifo_clear_o
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Sticky flag update: a set in the same cycle as a clear wins
  function [7:0] sticky;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] clr;
    begin
      sticky = (cur & ~clr) | set;
    end
  endfunction
  // Register select by byte address
  function is_addr;
    input [31:0] addr;
    input [31:0] byte_addr;
    begin
      is_addr = (addr == byte_addr);
    end
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg        awready_reg;
  reg        wready_reg;
  reg        bvalid_reg;
  reg [1:0]  bresp_reg;
  reg        aw_full_reg;
  reg        w_full_reg;
  reg [31:0] waddr_reg;
  reg [7:0]  wdata_reg;
  reg        wlane_reg;
  reg        arready_reg;
  reg        rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0]  rresp_reg;
  reg [1:0]  nak_mask_reg;
  reg        force_stall_reg;
  reg        resume_drive_reg;
  reg [7:0]  clear_record_reg;
  reg [2:0]  set_record_reg;
  reg [7:0]  occupancy_reg;
  reg        suspend_flag_reg;
  reg        nak_b_we_reg;
  reg        nak_a_we_reg;
  reg [1:0]  nak_wdata_reg;
  reg [7:0]  fifo_clear_reg;
  reg [7:0]  clr_pipe_reg [0:FIFO_CLR_DELAY-1];
  wire       aw_hs;
  wire       w_hs;
  wire       ar_hs;
  wire       do_write;
  wire [7:0] wbyte;
  wire       wr_mask;
  wire       wr_ctrl;
  wire       wr_fclr;
  wire       rd_clear_rec;
  wire       rd_set_rec;
  wire       rd_suspend;
  reg  [7:0] rd_byte;
  reg        rd_hit;
  wire       wr_hit;

  // --------------------------------------------------------------------
  // Bus handshakes
  // --------------------------------------------------------------------
  assign aw_hs    = s_axi_awvalid_i & awready_reg;
  assign w_hs     = s_axi_wvalid_i & wready_reg;
  assign ar_hs    = s_axi_arvalid_i & arready_reg;
  assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wbyte    = wdata_reg;
  // byte lane 0 only
  // A write without lane 0 enabled touches nothing but still answers
  assign wr_mask = do_write & wlane_reg &
                   is_addr(waddr_reg, `BYTE_ADDR(`IDX_NAK_WRITE_MASK));
  assign wr_ctrl = do_write & wlane_reg &
                   is_addr(waddr_reg, `BYTE_ADDR(`IDX_SIE_STALL_RESUME));
  assign wr_fclr = do_write & wlane_reg &
                   is_addr(waddr_reg, `BYTE_ADDR(`IDX_FIFO_CLEAR_A));

  // Read side effects fire on the address handshake
  assign rd_clear_rec = ar_hs &
    is_addr(s_axi_araddr_i, `BYTE_ADDR(`IDX_CLEAR_REQ_RECORD));
  assign rd_set_rec   = ar_hs &
    is_addr(s_axi_araddr_i, `BYTE_ADDR(`IDX_SET_REQ_RECORD));
  assign rd_suspend   = ar_hs &
    is_addr(s_axi_araddr_i, `BYTE_ADDR(`IDX_BUS_SUSPEND_STATUS));
  // Write address decode for the response code
  assign wr_hit = is_addr(waddr_reg, `BYTE_ADDR(`IDX_NAK_WRITE_MASK))     |
                  is_addr(waddr_reg, `BYTE_ADDR(`IDX_SIE_STALL_RESUME))   |
                  is_addr(waddr_reg, `BYTE_ADDR(`IDX_CLEAR_REQ_RECORD))   |
                  is_addr(waddr_reg, `BYTE_ADDR(`IDX_SET_REQ_RECORD))     |
                  is_addr(waddr_reg, `BYTE_ADDR(`IDX_EP_STATUS_OCC))      |
                  is_addr(waddr_reg, `BYTE_ADDR(`IDX_BUS_SUSPEND_STATUS)) |
                  is_addr(waddr_reg, `BYTE_ADDR(`IDX_FIFO_CLEAR_A));
  // Read mux; reserved bits zero
  always @* begin
    rd_byte = `REG8_RESET;
    rd_hit  = 1'b1;
    case (s_axi_araddr_i)
      `BYTE_ADDR(`IDX_NAK_WRITE_MASK): begin
        rd_byte[`NAK_MASK_B_BIT] = nak_mask_reg[1];
        rd_byte[`NAK_MASK_A_BIT] = nak_mask_reg[0];
      end
      `BYTE_ADDR(`IDX_SIE_STALL_RESUME): begin
        rd_byte[`FORCE_STALL_BIT]  = force_stall_reg;
        rd_byte[`RESUME_DRIVE_BIT] = resume_drive_reg;
      end
      `BYTE_ADDR(`IDX_CLEAR_REQ_RECORD): rd_byte = clear_record_reg;
      `BYTE_ADDR(`IDX_SET_REQ_RECORD): begin
        rd_byte[`SET_CONFIG_BIT]   = set_record_reg[2];
        rd_byte[`SET_FEAT_EP_BIT]  = set_record_reg[1];
        rd_byte[`SET_FEAT_DEV_BIT] = set_record_reg[0];
      end
      `BYTE_ADDR(`IDX_EP_STATUS_OCC): rd_byte = occupancy_reg;
      `BYTE_ADDR(`IDX_BUS_SUSPEND_STATUS):
        rd_byte[`SUSPEND_FLAG_BIT] = suspend_flag_reg;
      `BYTE_ADDR(`IDX_FIFO_CLEAR_A): rd_byte = `REG8_RESET;
      default: rd_hit = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------
  // Readies stay low from acceptance until the response is taken, so
  // only one write is ever in flight
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
      waddr_reg   <= `RDATA_ZERO;
      wdata_reg   <= `REG8_RESET;
      wlane_reg   <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
        waddr_reg   <= s_axi_awaddr_i;
      end
      if (w_hs) begin
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
        wdata_reg  <= s_axi_wdata_i[7:0];
        wlane_reg  <= s_axi_wstrb_i[0];
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= `RDATA_ZERO;
      rresp_reg   <= `RESP_OKAY;
    end else begin
      if (ar_hs) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= {24'h000000, rd_byte};
        rresp_reg   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready_i) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // NAK write mask and the gated NAK writes
  // --------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      nak_mask_reg  <= 2'h0;
      nak_b_we_reg  <= 1'b0;
      nak_a_we_reg  <= 1'b0;
      nak_wdata_reg <= 2'h0;
    end else begin
      // only mask bits stored
      // Bit 7 is not stored; leaves its effect to firmware discipline
      if (wr_mask)
        nak_mask_reg <= {wbyte[`NAK_MASK_B_BIT], wbyte[`NAK_MASK_A_BIT]};
      nak_b_we_reg  <= nak_ctrl_wr_i & nak_mask_reg[1];
      nak_a_we_reg  <= nak_ctrl_wr_i & nak_mask_reg[0];
      nak_wdata_reg <= nak_ctrl_wdata_i;
    end
  end

  // --------------------------------------------------------------------
  // Endpoint 0 force-stall and resume drive
  // --------------------------------------------------------------------
  // The stall output is registered, so a firmware set that lands after
  // the token is decoded only affects the next transfer
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      force_stall_reg  <= 1'b0;
      resume_drive_reg <= 1'b0;
    end else begin
      if (setup_token_i)
        force_stall_reg <= 1'b0;
      // firmware set gated
      // Clearing from firmware is always allowed
      if (wr_ctrl && (fw_request_active_i || !wbyte[`FORCE_STALL_BIT]))
        force_stall_reg <= wbyte[`FORCE_STALL_BIT];
      // overrun stalls
      // Hardware sets win over the SETUP clear; halt flag is elsewhere
      if (unsupported_wvalue_i || auto_req_overrun_i)
        force_stall_reg <= 1'b1;
      if (wr_ctrl && remote_wakeup_enable_i)
        resume_drive_reg <= wbyte[`RESUME_DRIVE_BIT];
    end
  end

  // --------------------------------------------------------------------
  // Request records, cleared by read
  // --------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      clear_record_reg <= `REG8_RESET;
      set_record_reg   <= 3'h0;
    end else begin
      clear_record_reg <= sticky(clear_record_reg, clear_req_done_i,
                                 {8{rd_clear_rec}});
      set_record_reg   <= (set_record_reg & ~{3{rd_set_rec}}) | set_req_done_i;
    end
  end

  // --------------------------------------------------------------------
  // FIFO clear delay line
  // --------------------------------------------------------------------
  // five clocks to status
  // Reads in the gap still show the old occupancy by design
  integer i;
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      fifo_clear_reg <= `REG8_RESET;
      for (i = 0; i < FIFO_CLR_DELAY; i = i + 1)
        clr_pipe_reg[i] <= `REG8_RESET;
    end else begin
      fifo_clear_reg  <= wr_fclr ? wbyte : `REG8_RESET;
      clr_pipe_reg[0] <= wr_fclr ? wbyte : `REG8_RESET;
      for (i = 1; i < FIFO_CLR_DELAY; i = i + 1)
        clr_pipe_reg[i] <= clr_pipe_reg[i-1];
    end
  end

  // --------------------------------------------------------------------
  // FIFO occupancy flags and bus suspend flag
  // --------------------------------------------------------------------
  // no endpoint qualification
  // Bits of unsupported endpoints just follow their inputs
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      occupancy_reg    <= `REG8_RESET;
      suspend_flag_reg <= 1'b0;
    end else begin
      occupancy_reg <= sticky(occupancy_reg,
        {int_fifo_set_i, bulk_out_toggle_i, bulk_in_set_i,
         ep0_tx_set_i, ep0_rx_data_i},
        {int_tx_done_i, bulk_out_cpu_empty_i, bulk_in_toggle_i,
         ep0_tx_done_i, ep0_rx_empty_i} | clr_pipe_reg[FIFO_CLR_DELAY-1]);
      suspend_flag_reg <= bus_suspend_evt_i |
                          (suspend_flag_reg & ~rd_suspend);
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign s_axi_awready_o      = awready_reg;
  assign s_axi_wready_o       = wready_reg;
  assign s_axi_bvalid_o       = bvalid_reg;
  assign s_axi_bresp_o        = bresp_reg;
  assign s_axi_arready_o      = arready_reg;
  assign s_axi_rvalid_o       = rvalid_reg;
  assign s_axi_rdata_o        = rdata_reg;
  assign s_axi_rresp_o        = rresp_reg;
  assign bulk_out_b_nak_we_o  = nak_b_we_reg;
  assign bulk_out_a_nak_we_o  = nak_a_we_reg;
  assign bulk_out_nak_wdata_o = nak_wdata_reg;
  assign force_stall_o        = force_stall_reg;
  assign resume_drive_o       = resume_drive_reg;
  assign fifo_clear_o         = fifo_clear_reg;

endmodule // usb_function_ep_status_ctrl

// ===== tb/usb_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// SIE-side event source for endpoint 0
// ----------------------------------------------------------------------
module usb_host_model (
  input  logic       clk_sys_i,
  input  logic [2:0] req_i,
  output logic       setup_o      = 1'b0,
  output logic       bad_wvalue_o = 1'b0,
  output logic       overrun_o    = 1'b0
);
  // single-cycle events
  // Registered, so each event trails req_i by one clock and lasts as long as it
  always @(posedge clk_sys_i) begin
    setup_o      <= req_i[0];
    bad_wvalue_o <= req_i[1];
    overrun_o    <= req_i[2];
  end
endmodule // usb_host_model

// ===== tb/ep_status_ctrl_properties.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Port-level checker
// ----------------------------------------------------------------------
module ep_status_ctrl_properties #(
  parameter integer FIFO_CLR_DELAY = 5
) (
  input wire        clk_sys_i,
  input wire        rstn_i,
  input wire        s_axi_awvalid_i,
  input wire        s_axi_awready_o,
  input wire        s_axi_wvalid_i,
  input wire        s_axi_wready_o,
  input wire        s_axi_bvalid_o,
  input wire        s_axi_arvalid_i,
  input wire        s_axi_arready_o,
  input wire        s_axi_rvalid_o,
  input wire [31:0] s_axi_rdata_o,
  input wire        nak_ctrl_wr_i,
  input wire [1:0]  nak_ctrl_wdata_i,
  input wire        bulk_out_b_nak_we_o,
  input wire        bulk_out_a_nak_we_o,
  input wire [1:0]  bulk_out_nak_wdata_o,
  input wire        setup_token_i,
  input wire        unsupported_wvalue_i,
  input wire        auto_req_overrun_i,
  input wire        fw_request_active_i,
  input wire        remote_wakeup_enable_i,
  input wire        force_stall_o,
  input wire        resume_drive_o,
  input wire [7:0]  fifo_clear_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  chk_nak_we_cause: assert property (
    (bulk_out_a_nak_we_o || bulk_out_b_nak_we_o) |-> $past(nak_ctrl_wr_i)
    && bulk_out_nak_wdata_o == $past(nak_ctrl_wdata_i))
    else $error("nak write enable without a firmware write");
  chk_stall_hw_set: assert property (
    (unsupported_wvalue_i || auto_req_overrun_i) |=> force_stall_o)
    else $error("force stall not set by hardware event");
  // Idle bus only, so a firmware write cannot overrule the clear
  chk_stall_setup_clr: assert property (
    setup_token_i && !unsupported_wvalue_i && !auto_req_overrun_i
    && s_axi_awready_o && s_axi_wready_o |=> !force_stall_o)
    else $error("force stall kept after setup token");
  chk_stall_fw_gate: assert property (
    !fw_request_active_i && !force_stall_o && !unsupported_wvalue_i
    && !auto_req_overrun_i |=> !force_stall_o)
    else $error("force stall rose outside a firmware request");
  chk_resume_gate: assert property (
    !remote_wakeup_enable_i |=> $stable(resume_drive_o))
    else $error("resume drive changed without wakeup enable");
  chk_b_after_both: assert property (
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
    else $error("write response late");
  chk_r_answer: assert property (
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read response late");
  chk_rdata_upper: assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000)
    else $error("read data above bit 7 not zero");
  chk_fifo_clr_pulse: assert property (
    fifo_clear_o != 8'h00 |=> fifo_clear_o == 8'h00)
    else $error("fifo clear pulse longer than one cycle");
endmodule // ep_status_ctrl_properties

bind usb_function_ep_status_ctrl ep_status_ctrl_properties #(
  .FIFO_CLR_DELAY(FIFO_CLR_DELAY)
) i_ep_status_ctrl_properties (
  .clk_sys_i, .rstn_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rdata_o, .nak_ctrl_wr_i,
  .nak_ctrl_wdata_i, .bulk_out_b_nak_we_o, .bulk_out_a_nak_we_o,
  .bulk_out_nak_wdata_o, .setup_token_i, .unsupported_wvalue_i,
  .auto_req_overrun_i, .fw_request_active_i, .remote_wakeup_enable_i,
  .force_stall_o, .resume_drive_o, .fifo_clear_o
);

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam [31:0] A_MASK = 32'h3FFFF80C, A_SIE = 32'hFFFFF810;
  localparam [31:0] A_CLR = 32'hFFFFF814, A_SET = 32'hFFFFF818;
  localparam [31:0] A_OCC = 32'h3FFFF81C, A_SUS = 32'hFFFFF820;
  localparam [31:0] A_FCLR = 32'hFFFFF828, A_BAD = 32'h00000100;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0;
  logic [31:0] s_axi_awaddr_i = '0, s_axi_wdata_i = '0, s_axi_araddr_i = '0;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, nak_ctrl_wr_i = 0;
  logic [1:0] nak_ctrl_wdata_i = '0, int_fifo_set_i = '0, int_tx_done_i = '0;
  logic [1:0] bulk_out_toggle_i = '0, bulk_out_cpu_empty_i = '0;
  logic [1:0] bulk_in_set_i = '0, bulk_in_toggle_i = '0;
  logic fw_request_active_i = 0, remote_wakeup_enable_i = 0;
  logic ep0_tx_set_i = 0, ep0_tx_done_i = 0, ep0_rx_data_i = 0;
  logic ep0_rx_empty_i = 0, bus_suspend_evt_i = 0;
  logic [7:0] clear_req_done_i = '0;
  logic [2:0] set_req_done_i = '0, host_req = '0;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  wire s_axi_rvalid_o, bulk_out_b_nak_we_o, bulk_out_a_nak_we_o;
  wire force_stall_o, resume_drive_o;
  wire setup_token_i, unsupported_wvalue_i, auto_req_overrun_i;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o, bulk_out_nak_wdata_o;
  wire [31:0] s_axi_rdata_o;
  wire [7:0] fifo_clear_o;
  int n_errors = 0, n_compared = 0, cycles = 0;

  usb_function_ep_status_ctrl #(.FIFO_CLR_DELAY(5))
    i_usb_function_ep_status_ctrl (
    .clk_sys_i, .rstn_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .nak_ctrl_wr_i, .nak_ctrl_wdata_i,
    .bulk_out_b_nak_we_o, .bulk_out_a_nak_we_o, .bulk_out_nak_wdata_o,
    .setup_token_i, .unsupported_wvalue_i, .auto_req_overrun_i,
    .fw_request_active_i, .remote_wakeup_enable_i, .force_stall_o,
    .resume_drive_o, .clear_req_done_i, .set_req_done_i, .int_fifo_set_i,
    .int_tx_done_i, .bulk_out_toggle_i, .bulk_out_cpu_empty_i,
    .bulk_in_set_i, .bulk_in_toggle_i, .ep0_tx_set_i, .ep0_tx_done_i,
    .ep0_rx_data_i, .ep0_rx_empty_i, .bus_suspend_evt_i, .fifo_clear_o);
  usb_host_model i_usb_host_model (.clk_sys_i, .req_i(host_req),
    .setup_o(setup_token_i), .bad_wvalue_o(unsupported_wvalue_i),
    .overrun_o(auto_req_overrun_i));

  // 10 MHz clock; the ceiling is far above the few hundred cycles used
  always #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input [31:0] a, input [7:0] d, input [1:0] er);
    bit done;
    done = 0;
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h0, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    while (!done) begin
      @(posedge clk_sys_i);
      if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o === 1'b1) begin
        chk("bresp", er, s_axi_bresp_o);
        s_axi_bready_i <= 1'b0;
        done = 1;
      end
    end
  endtask
  task automatic rchk(input string nm, input [31:0] a, input [31:0] e,
                      input [1:0] er);
    bit done;
    done = 0;
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    while (!done) begin
      @(posedge clk_sys_i);
      if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o === 1'b1) begin
        chk(nm, e, s_axi_rdata_o);
        chk("rresp", er, s_axi_rresp_o);
        s_axi_rready_i <= 1'b0;
        done = 1;
      end
    end
  endtask
  // Event pulse from the far side, then a look two edges on
  task automatic host(input [2:0] v, input e);
    host_req <= v;
    @(posedge clk_sys_i);
    host_req <= 3'h0;
    repeat (2) @(posedge clk_sys_i);
    chk("force_stall", e, force_stall_o);
  endtask
  task automatic nak_try(input [1:0] d, input ea, input eb);
    nak_ctrl_wr_i <= 1'b1;
    nak_ctrl_wdata_i <= d;
    @(posedge clk_sys_i);
    nak_ctrl_wr_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("nak_we_a", ea, bulk_out_a_nak_we_o);
    chk("nak_we_b", eb, bulk_out_b_nak_we_o);
    chk("nak_wdata", d, bulk_out_nak_wdata_o);
  endtask
  // Occupancy set and clear events, one cycle long
  task automatic ev(input [7:0] s, input [7:0] c);
    {int_fifo_set_i, bulk_out_toggle_i, bulk_in_set_i, ep0_tx_set_i,
     ep0_rx_data_i} <= s;
    {int_tx_done_i, bulk_out_cpu_empty_i, bulk_in_toggle_i, ep0_tx_done_i,
     ep0_rx_empty_i} <= c;
    @(posedge clk_sys_i);
    {int_fifo_set_i, bulk_out_toggle_i, bulk_in_set_i, ep0_tx_set_i} <= '0;
    {int_tx_done_i, bulk_out_cpu_empty_i, bulk_in_toggle_i} <= '0;
    {ep0_rx_data_i, ep0_tx_done_i, ep0_rx_empty_i} <= '0;
  endtask

  task automatic t_reset();
    rchk("mask", A_MASK, 0, 0);
    rchk("sie", A_SIE, 0, 0);
    rchk("occ", A_OCC, 0, 0);
    rchk("unmapped", A_BAD, 0, 2);
    wr(A_BAD, 8'hFF, 2);
  endtask
  // mask gating; bit 7 always written 0
  task automatic t_nak();
    nak_try(2'h3, 0, 0);
    wr(A_MASK, 8'h7F, 0);
    rchk("mask", A_MASK, 32'h0C, 0);
    nak_try(2'h2, 1, 1);
    wr(A_MASK, 8'h04, 0);
    nak_try(2'h1, 1, 0);
    s_axi_wstrb_i <= 4'h0;
    wr(A_MASK, 8'h08, 0);
    s_axi_wstrb_i <= 4'hF;
    rchk("mask_lane", A_MASK, 32'h04, 0);
  endtask
  // stall control; bit 2 always written 0
  task automatic t_stall();
    wr(A_SIE, 8'h08, 0);
    rchk("stall_off", A_SIE, 0, 0);
    fw_request_active_i <= 1'b1;
    wr(A_SIE, 8'h08, 0);
    chk("force_stall", 1, force_stall_o);
    rchk("stall_on", A_SIE, 32'h08, 0);
    fw_request_active_i <= 1'b0;
    host(3'h1, 0);
    host(3'h2, 1);
    host(3'h1, 0);
    host(3'h4, 1);
    host(3'h1, 0);
  endtask
  // resume drive held until firmware clears it
  task automatic t_resume();
    wr(A_SIE, 8'h01, 0);
    chk("resume", 0, resume_drive_o);
    remote_wakeup_enable_i <= 1'b1;
    wr(A_SIE, 8'h01, 0);
    repeat (20) begin
      @(posedge clk_sys_i);
      chk("resume", 1, resume_drive_o);
    end
    wr(A_SIE, 8'h00, 0);
    chk("resume", 0, resume_drive_o);
  endtask
  task automatic t_records();
    bit [7:0] m [3] = '{8'h01, 8'h04, 8'h80};
    for (int i = 0; i < 8; i++) begin
      clear_req_done_i <= 8'h01 << i;
      @(posedge clk_sys_i);
      clear_req_done_i <= '0;
      rchk("clr_rec", A_CLR, 32'h01 << i, 0);
      rchk("clr_rec", A_CLR, 0, 0);
    end
    for (int i = 0; i < 3; i++) begin
      set_req_done_i <= 3'h1 << i;
      @(posedge clk_sys_i);
      set_req_done_i <= '0;
      rchk("set_rec", A_SET, m[i], 0);
      rchk("set_rec", A_SET, 0, 0);
    end
  endtask
  // occupancy flags and delayed fifo clear
  task automatic t_occ();
    ev(8'hFF, 8'h00);
    rchk("occ", A_OCC, 32'hFF, 0);
    ev(8'h00, 8'b01_10_01_1_0);
    rchk("occ", A_OCC, 32'h99, 0);
    ev(8'h00, 8'b10_01_10_0_1);
    rchk("occ", A_OCC, 0, 0);
    ev(8'hFF, 8'h00);
    wr(A_FCLR, 8'hFF, 0);
    chk("fifo_clear", 32'hFF, fifo_clear_o);
    rchk("occ_early", A_OCC, 32'hFF, 0);
    repeat (6) @(posedge clk_sys_i);
    rchk("occ_late", A_OCC, 0, 0);
    bus_suspend_evt_i <= 1'b1;
    @(posedge clk_sys_i);
    bus_suspend_evt_i <= 1'b0;
    rchk("suspend", A_SUS, 32'h80, 0);
    rchk("suspend", A_SUS, 0, 0);
  endtask

  initial begin
    repeat (12) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    t_reset();
    t_nak();
    t_stall();
    t_resume();
    t_records();
    t_occ();
    conclude();
  end
endmodule // testbench
